//--- verilog/rcp_pkg.sv
package rcp_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] PORT_ADDR = 8'ha0;
  localparam logic [7:0] ROUTE_ADDR = 8'hb3;
  localparam logic [7:0] PORT_RESET = 8'h08;
  localparam logic [1:0] ROUTE_RESET = 2'h0;
  // ****************************************
  // read field positions
  // ****************************************
  localparam int RD_ADDR_MATCH = 7;
  localparam int RD_CARRIER = 6;
  localparam int RD_READY = 5;
  localparam int RD_CONV_DONE = 4;
  localparam int RD_SER_OUT = 2;
  // ****************************************
  // write field positions
  // ****************************************
  localparam int WR_ACTIVE = 5;
  localparam int WR_TX_SEL = 4;
  localparam int WR_SEL_N = 3;
  localparam int WR_SER_IN = 1;
  localparam int WR_SER_CLK = 0;
  // ****************************************
  // routing codes
  // ****************************************
  localparam logic [1:0] ROUTE_NONE = 2'h0;
  localparam logic [1:0] ROUTE_BOOT = 2'h1;
  localparam int ROUTE_RADIO_BIT = 1;
  // ****************************************
  // transceiver mode
  // ****************************************
  typedef enum logic [2:0] {
    RCP_STANDBY = 3'h1,
    RCP_RECEIVE = 3'h2,
    RCP_TRANSMIT = 3'h4
  } rcp_mode_t;
endpackage

//--- verilog/rcp_radio_control_port.sv
`timescale 1ns/1ns
// Notes on behaviour
// - port register at 0xa0, 8 bits, latch resets to 0x08.
// - route select at 0xb3: 00 unused, 01 boot port, 1x radio lines.
// - read: bits 7..4 status flags, bit 2 serial out, 3/1/0 read zero.
// - write bit 5 radio enable, bit 4 transmit select; bits 7,6 ignored.
// - write bit 3 select_n, bit 1 serial in, bit 0 clock; bit 2 ignored.
// - route 1x lets the serial engine override the serial lines.
// - route 0x connects radio lines straight to latch bits and inputs.
// - not bidirectional; reads and writes reach different signals.
// - reset forces radio outputs to defaults, clock or not.
// - outputs stay at defaults after reset until a port write or a route select write.
// - enable 0 standby, enable 1 tx 0 receive, both 1 transmit.
module rcp_radio_control_port (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWr,
  input wire logic sfrRd,
  input wire logic [7:0] sfrWrData,
  output logic [7:0] sfrRdData,
  input wire logic addrMatchFlag,
  input wire logic carrierSenseFlag,
  input wire logic payloadReadyFlag,
  input wire logic convDoneFlag,
  input wire logic internalSerialDataOut,
  output logic radioActiveEnable,
  output logic txSelect,
  output logic radioAdcSelect_n,
  output logic internalSerialDataIn,
  output logic internalSerialClock,
  input wire logic engSerialClock,
  input wire logic engSerialDataIn,
  output logic engSerialDataOut,
  output logic [1:0] routeSelect,
  output rcp_pkg::rcp_mode_t radioMode
);
  import rcp_pkg::*;

  logic [7:0] portLatch_ff;
  logic [1:0] route_ff;
  logic [7:0] nxt_rdData;
  logic radioRoute;
  rcp_mode_t nxt_mode;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    hit = (a == ref_a);
  endfunction

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      portLatch_ff <= PORT_RESET;
    end else if (clkEn && sfrWr && hit(sfrAddr, PORT_ADDR)) begin
      portLatch_ff <= sfrWrData;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      route_ff <= ROUTE_RESET;
    end else if (clkEn && sfrWr && hit(sfrAddr, ROUTE_ADDR)) begin
      route_ff <= sfrWrData[1:0];
    end
  end

  assign radioRoute = route_ff[ROUTE_RADIO_BIT];

  // ****************************************
  // read path
  // ****************************************
  always_comb begin
    nxt_rdData = 8'h00;
    if (hit(sfrAddr, PORT_ADDR)) begin
      nxt_rdData[RD_ADDR_MATCH] = addrMatchFlag;
      nxt_rdData[RD_CARRIER] = carrierSenseFlag;
      nxt_rdData[RD_READY] = payloadReadyFlag;
      nxt_rdData[RD_CONV_DONE] = convDoneFlag;
      nxt_rdData[RD_SER_OUT] = internalSerialDataOut;
    end else if (hit(sfrAddr, ROUTE_ADDR)) begin
      nxt_rdData[1:0] = route_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfrRdData <= 8'h00;
    end else if (clkEn && sfrRd) begin
      sfrRdData <= nxt_rdData;
    end
  end

  // ****************************************
  // radio outputs
  // ****************************************
  always_comb begin
    case ({portLatch_ff[WR_ACTIVE], portLatch_ff[WR_TX_SEL]})
      2'b10: nxt_mode = RCP_RECEIVE;
      2'b11: nxt_mode = RCP_TRANSMIT;
      default: nxt_mode = RCP_STANDBY;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      radioActiveEnable <= PORT_RESET[WR_ACTIVE];
      txSelect <= PORT_RESET[WR_TX_SEL];
      radioAdcSelect_n <= PORT_RESET[WR_SEL_N];
      internalSerialDataIn <= PORT_RESET[WR_SER_IN];
      internalSerialClock <= PORT_RESET[WR_SER_CLK];
      engSerialDataOut <= 1'b0;
      routeSelect <= ROUTE_RESET;
      radioMode <= RCP_STANDBY;
    end else if (clkEn) begin
      radioActiveEnable <= portLatch_ff[WR_ACTIVE];
      txSelect <= portLatch_ff[WR_TX_SEL];
      radioAdcSelect_n <= portLatch_ff[WR_SEL_N];
      routeSelect <= route_ff;
      radioMode <= nxt_mode;
      if (radioRoute) begin
        internalSerialDataIn <= engSerialDataIn;
        internalSerialClock <= engSerialClock;
        engSerialDataOut <= internalSerialDataOut;
      end else begin
        internalSerialDataIn <= portLatch_ff[WR_SER_IN];
        internalSerialClock <= portLatch_ff[WR_SER_CLK];
        engSerialDataOut <= 1'b0;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_portWrite;
    @(posedge sys_clk) disable iff (!rst_n)
    (clkEn && sfrWr && sfrAddr == PORT_ADDR) ##1 clkEn |=>
      radioActiveEnable == $past(sfrWrData[WR_ACTIVE], 2) &&
      radioAdcSelect_n == $past(sfrWrData[WR_SEL_N], 2);
  endproperty
  port_write_drives_a: assert property (p_portWrite)
    else $error("port write did not reach radio outputs");

  latch_holds_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !(sfrWr && sfrAddr == PORT_ADDR) |=> $stable(portLatch_ff))
    else $error("port latch changed without a write");

  read_layout_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (clkEn && sfrRd && sfrAddr == PORT_ADDR) |=>
      sfrRdData[3] == 1'b0 && sfrRdData[1:0] == 2'h0 &&
      sfrRdData[RD_ADDR_MATCH] == $past(addrMatchFlag) &&
      sfrRdData[RD_CARRIER] == $past(carrierSenseFlag) &&
      sfrRdData[RD_READY] == $past(payloadReadyFlag) &&
      sfrRdData[RD_CONV_DONE] == $past(convDoneFlag) &&
      sfrRdData[RD_SER_OUT] == $past(internalSerialDataOut))
    else $error("port read layout wrong");

  route_read_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (clkEn && sfrRd && sfrAddr == ROUTE_ADDR) |=>
      sfrRdData == {6'h00, $past(route_ff)})
    else $error("route read wrong");

  unmapped_read_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (clkEn && sfrRd && sfrAddr != PORT_ADDR && sfrAddr != ROUTE_ADDR) |=>
      sfrRdData == 8'h00)
    else $error("unmapped read not zero");

  engine_route_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (clkEn && radioRoute) |=>
      internalSerialClock == $past(engSerialClock) &&
      internalSerialDataIn == $past(engSerialDataIn) &&
      engSerialDataOut == $past(internalSerialDataOut))
    else $error("engine lines not routed");

  soft_route_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (clkEn && !radioRoute) |=>
      internalSerialDataIn == $past(portLatch_ff[WR_SER_IN]) &&
      internalSerialClock == $past(portLatch_ff[WR_SER_CLK]) &&
      engSerialDataOut == 1'b0)
    else $error("software route wrong");

  latch_select_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clkEn |=> radioAdcSelect_n == $past(portLatch_ff[WR_SEL_N]) &&
      txSelect == $past(portLatch_ff[WR_TX_SEL]))
    else $error("select lines not from latch");

  route_write_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (clkEn && sfrWr && sfrAddr == ROUTE_ADDR) |=>
      route_ff == $past(sfrWrData[1:0]))
    else $error("route select not stored");

  mode_map_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clkEn |=> radioMode != RCP_TRANSMIT ||
      ($past(portLatch_ff[WR_ACTIVE]) && $past(portLatch_ff[WR_TX_SEL])))
    else $error("transmit mode without enable and select");

  standby_map_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clkEn |=> $past(portLatch_ff[WR_ACTIVE]) || radioMode == RCP_STANDBY)
    else $error("standby not kept while disabled");

  freeze_hold_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !clkEn |=> $stable(portLatch_ff) && $stable(route_ff) &&
      $stable(sfrRdData) && $stable(radioMode) &&
      $stable(internalSerialClock))
    else $error("state changed while clock enable low");

  reset_default_a: assert property (
    @(posedge sys_clk)
    $rose(rst_n) |-> portLatch_ff == PORT_RESET &&
      route_ff == ROUTE_RESET &&
      radioAdcSelect_n == PORT_RESET[WR_SEL_N] &&
      radioMode == RCP_STANDBY)
    else $error("outputs not at default after reset");

  cov_transmit_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    radioMode == RCP_TRANSMIT);
  cov_receive_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    radioMode == RCP_RECEIVE);
  cov_engine_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    radioRoute && engSerialClock);
  cov_read_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    sfrRd && sfrAddr == PORT_ADDR && addrMatchFlag);
  cov_freeze_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    !clkEn && sfrWr && sfrAddr == PORT_ADDR);

endmodule

//--- test/rcp_radio_model.sv
`timescale 1ns/1ns
module rcp_radio_model (
  input wire logic sys_clk,
  input wire logic radioAdcSelect_n,
  input wire logic internalSerialClock,
  input wire logic internalSerialDataIn,
  output logic internalSerialDataOut
);
  logic [7:0] shift_ff = 8'h00;
  logic last_ff = 1'b0;
  logic sck_ff = 1'b0;
  // shift on rising serial clock only while selected
  always @(posedge sys_clk) begin
    sck_ff <= internalSerialClock;
    if (!radioAdcSelect_n && internalSerialClock && !sck_ff) begin
      shift_ff <= {shift_ff[6:0], internalSerialDataIn};
    end
    if (!radioAdcSelect_n) last_ff <= shift_ff[7];
  end
  // released line shows the inverse of its last value
  assign internalSerialDataOut =
    radioAdcSelect_n ? ~last_ff : shift_ff[7];
endmodule

//--- test/tb_radio_control_port.sv
`timescale 1ns/1ns
module tb_radio_control_port;
  import rcp_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sfrWr = 1'b0;
  logic sfrRd = 1'b0;
  logic clkEn = 1'b1;
  logic rdSeen_ff = 1'b0;
  logic engClk = 1'b0;
  logic engDin = 1'b0;
  logic [7:0] sfrAddr = 8'h00;
  logic [7:0] sfrWrData = 8'h00;
  logic [3:0] st = 4'h0;
  logic [7:0] rdData, b, d;
  logic rae, txs, seln, sdi, sck, so, engDo;
  logic [1:0] route;
  rcp_mode_t mode;
  logic [7:0] expQ[$];
  integer seed = 19;
  int fails = 0;
  int comparisons = 0;
  always #20 sys_clk = ~sys_clk;
  rcp_radio_control_port dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .clkEn(clkEn), .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrRd(sfrRd),
    .sfrWrData(sfrWrData), .sfrRdData(rdData), .addrMatchFlag(st[3]),
    .carrierSenseFlag(st[2]), .payloadReadyFlag(st[1]),
    .convDoneFlag(st[0]), .internalSerialDataOut(so),
    .radioActiveEnable(rae), .txSelect(txs), .radioAdcSelect_n(seln),
    .internalSerialDataIn(sdi), .internalSerialClock(sck),
    .engSerialClock(engClk), .engSerialDataIn(engDin),
    .engSerialDataOut(engDo), .routeSelect(route), .radioMode(mode));
  rcp_radio_model peer (.sys_clk(sys_clk), .radioAdcSelect_n(seln),
    .internalSerialClock(sck), .internalSerialDataIn(sdi),
    .internalSerialDataOut(so));
  task automatic cmpOut(input logic [10:0] got, input logic [10:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmpRd(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    sfrAddr <= a;
    sfrWrData <= v;
    sfrWr <= 1'b1;
    @(posedge sys_clk);
    sfrWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    sfrAddr <= a;
    sfrRd <= 1'b1;
    expQ.push_back(e);
    @(posedge sys_clk);
    sfrRd <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] v, input logic [1:0] r, input int n);
    logic [2:0] m;
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
    m = !v[5] ? RCP_STANDBY : v[4] ? RCP_TRANSMIT : RCP_RECEIVE;
    cmpOut({route, mode, rae, txs, seln, sdi, sck, engDo},
      {r, m, v[5:3], r[1] ? engDin : v[1], r[1] ? engClk : v[0], r[1] & so});
  endtask
  // read data checked one edge after the read is taken
  always @(posedge sys_clk) begin
    rdSeen_ff <= sfrRd;
    if (rdSeen_ff) cmpRd(rdData, expQ.pop_front());
  end
  initial begin
    chk(PORT_RESET, 2'h0, 1);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(ROUTE_ADDR, 8'h00);
    rd(8'h55, 8'h00);
    wr(8'h55, 8'hff);
    chk(PORT_RESET, 2'h0, 4);
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      d[5:3] = {i[1:0], 1'b1};
      wr(PORT_ADDR, d);
      chk(d, 2'h0, 2);
      b = 8'($random(seed));
      @(posedge sys_clk);
      st <= b[3:0];
      rd(PORT_ADDR, {b[3:0], 1'b0, so, 2'h0});
    end
    b = 8'($random(seed));
    for (int k = 7; k >= 0; k--) begin
      wr(PORT_ADDR, {6'h00, b[k], 1'b0});
      wr(PORT_ADDR, {6'h00, b[k], 1'b1});
    end
    chk({6'h00, b[0], 1'b1}, 2'h0, 2);
    // write with clock enable low must leave everything frozen
    @(posedge sys_clk);
    clkEn <= 1'b0;
    wr(PORT_ADDR, 8'h30);
    chk({6'h00, b[0], 1'b1}, 2'h0, 2);
    @(posedge sys_clk);
    clkEn <= 1'b1;
    chk({6'h00, b[0], 1'b1}, 2'h0, 1);
    rd(PORT_ADDR, {st, 1'b0, b[7], 2'h0});
    for (int r = 0; r < 4; r++) begin
      b = 8'($random(seed));
      @(posedge sys_clk);
      engClk <= b[0];
      engDin <= b[1];
      wr(ROUTE_ADDR, {b[7:2], r[1:0]});
      rd(ROUTE_ADDR, {6'h00, r[1:0]});
      d = 8'($random(seed));
      wr(PORT_ADDR, d);
      chk(d, r[1:0], 3);
    end
    @(posedge sys_clk);
    rst_n <= 1'b0;
    chk(PORT_RESET, 2'h0, 1);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(ROUTE_ADDR, 8'h00);
    chk(PORT_RESET, 2'h0, 3);
    tally_and_finish();
  end
  initial begin
    #400000;
    fails++;
    tally_and_finish();
  end
endmodule
